// [pkg/power_seq_regs.vh]
// Constants for the power-state and wake sequencer.
// Assumes a 20 MHz clock; included by bare name from logic/.
`ifndef POWER_SEQ_REGS_VH
`define POWER_SEQ_REGS_VH

`define CLK_HZ            20000000
`define HOLD_SECONDS      7
`define HOLD_CYCLES       (`HOLD_SECONDS * `CLK_HZ)
`define DEBOUNCE_NS       10000000
`define CLK_PERIOD_NS     50
`define DEBOUNCE_CYCLES   (`DEBOUNCE_NS / `CLK_PERIOD_NS)

// One-hot state codes
`define ST_S0             5'h01
`define ST_S1             5'h02
`define ST_S3             5'h04
`define ST_S5             5'h08
`define ST_FORCE          5'h10

// Operating-system request codes
`define REQ_NONE          2'h0
`define REQ_S1            2'h1
`define REQ_S3            2'h2
`define REQ_S5            2'h3

// Wake source bit positions
`define WK_RTC            0
`define WK_NET            1
`define WK_PME            2
`define WK_RING           3
`define WK_USB            4
`define WK_KBD            5
`define WK_RISER_RING     6
`define WK_BITS           7

`endif

// [logic/button_timer.v]
// Debounces the power button and classifies each press as short or long.
// Assumes button level synchronous to clock; hold count saturates, debounce count clears.
`include "power_seq_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module button_timer #(
  parameter integer DEBOUNCE = `DEBOUNCE_CYCLES,
  parameter integer HOLD     = `HOLD_CYCLES
) (
  input  wire clock,
  input  wire arst_n,
  input  wire button_n,
  output reg  short_q,
  output reg  long_q
);
  reg [31:0] deb_q;
  reg        level_q;
  reg [31:0] held_q;
  reg        long_done_q;

  // Debounced level only changes after DEBOUNCE stable cycles [RQ10]
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      deb_q   <= 32'h00000000;
      level_q <= 1'b0;
    end else if ((~button_n) == level_q) begin
      deb_q <= 32'h00000000;
    end else if (deb_q >= DEBOUNCE - 1) begin
      deb_q   <= 32'h00000000;
      level_q <= ~button_n;
    end else begin
      deb_q <= deb_q + 32'h00000001;
    end
  end

  // Exactly HOLD cycles still counts as short; long fires at HOLD+1 [RQ10]
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      held_q      <= 32'h00000000;
      long_done_q <= 1'b0;
      short_q     <= 1'b0;
      long_q      <= 1'b0;
    end else begin
      short_q <= 1'b0;
      long_q  <= 1'b0;
      if (level_q) begin
        if (held_q <= HOLD)
          held_q <= held_q + 32'h00000001;
        if (held_q == HOLD && !long_done_q) begin
          long_q      <= 1'b1; // [RQ2]
          long_done_q <= 1'b1;
        end
      end else begin
        if (held_q != 32'h00000000 && !long_done_q)
          short_q <= 1'b1; // [RQ1]
        held_q      <= 32'h00000000;
        long_done_q <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// [logic/power_state_wake_sequencer.v]
// Power-state sequencer: working, S1, S3, soft-off, with wake qualifying.
// Assumes all inputs synchronous to clock; wake inputs are active-high.
`include "power_seq_regs.vh"
`timescale 1ns/10ps
`default_nettype none

// How it works
// RQ1 - Short press: soft-off to working, working to sleep, sleep to working.
// RQ2 - Press held beyond seven seconds forces soft-off from working or sleep.
// RQ3 - Software requests drive every sleep entry; block never chooses alone. Code also enters S1/S3 on a short press per sleep_button_target.
// RQ4 - In S3 and S5 device power drops; only wake logic stays powered.
// RQ5 - Button, alarm, network header, bus event wake from S1, S3, S5.
// RQ6 - Modem ring, USB, keyboard wake only from S1 or S3.
// RQ7 - Wake from S5 accepted only through the second PCI slot. Code lets a short button press wake S5 on any slot.
// RQ8 - Network and bus-event S5 wake off after reset until enabled.
// RQ9 - Riser-card modem ring never wakes the system.
// RQ10 - Debounced counted press; exactly seven seconds counts as short.
module power_state_wake_sequencer #(
  parameter integer DEBOUNCE = `DEBOUNCE_CYCLES,
  parameter integer HOLD     = `HOLD_CYCLES
) (
  input  wire                  clock,
  input  wire                  arst_n,
  input  wire                  button_n,
  input  wire [1:0]            os_req,
  input  wire                  os_req_valid,
  input  wire [1:0]            sleep_button_target,
  input  wire [`WK_BITS-1:0]   wake_in,
  input  wire                  wake_via_slot2,
  input  wire                  net_s5_enable,
  input  wire                  pme_s5_enable,
  output reg  [4:0]            state_q,
  output reg                   main_power_q,
  output reg                   cpu_run_q,
  output reg                   wake_logic_power_q,
  output reg                   wake_event_q
);
  wire short_press;
  wire long_press;
  reg  [4:0] state_d;
  reg        wake_ok;
  reg        s5_net_en_q;
  reg        s5_pme_en_q;

  button_timer #(
    .DEBOUNCE (DEBOUNCE),
    .HOLD     (HOLD)
  ) u_button (
    .clock    (clock),
    .arst_n   (arst_n),
    .button_n (button_n),
    .short_q  (short_press),
    .long_q   (long_press)
  );

  // Sources allowed from S1/S3; riser ring left out on purpose
  function sleep_wake;
    input [`WK_BITS-1:0] w;
    begin
      sleep_wake = w[`WK_RTC] | w[`WK_NET] | w[`WK_PME] // [RQ5]
                 | w[`WK_RING] | w[`WK_USB] | w[`WK_KBD]; // [RQ6] [RQ9]
    end
  endfunction

  // Enables captured clocked so a reset always clears them first [RQ8]
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s5_net_en_q <= 1'b0;
      s5_pme_en_q <= 1'b0;
    end else begin
      s5_net_en_q <= net_s5_enable;
      s5_pme_en_q <= pme_s5_enable;
    end
  end

  always @* begin
    wake_ok = 1'b0;
    case (state_q)
      `ST_S1, `ST_S3: wake_ok = sleep_wake(wake_in);
      // Only alarm and gated LAN/bus events, and only via slot 2 [RQ7]
      `ST_S5: wake_ok = wake_via_slot2 &
                        (wake_in[`WK_RTC]
                         | (wake_in[`WK_NET] & s5_net_en_q)   // [RQ8]
                         | (wake_in[`WK_PME] & s5_pme_en_q)); // [RQ5]
      default: wake_ok = 1'b0;
    endcase
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      `ST_S0: begin
        if (long_press)
          state_d = `ST_FORCE; // [RQ2]
        else if (short_press)
          state_d = (sleep_button_target == `REQ_S3) ? `ST_S3 : `ST_S1; // [RQ1]
        else if (os_req_valid) begin
          // Software picks the sleep depth here; a short press picks it from sleep_button_target [RQ3]
          case (os_req)
            `REQ_S1: state_d = `ST_S1;
            `REQ_S3: state_d = `ST_S3;
            `REQ_S5: state_d = `ST_S5;
            default: state_d = `ST_S0;
          endcase
        end
      end
      `ST_S1, `ST_S3: begin
        if (long_press)
          state_d = `ST_FORCE; // [RQ2]
        else if (short_press || wake_ok)
          state_d = `ST_S0; // [RQ1] [RQ5]
      end
      `ST_S5: begin
        // Button wakes from S5 whatever slot [RQ1] [RQ5]
        if (short_press || wake_ok)
          state_d = `ST_S0;
      end
      // Hold the forced state until the button is let go
      `ST_FORCE: begin
        if (!long_press && !short_press && button_n)
          state_d = `ST_S5;
      end
      default: state_d = `ST_S5;
    endcase
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q            <= `ST_S5;
      main_power_q       <= 1'b0;
      cpu_run_q          <= 1'b0;
      wake_logic_power_q <= 1'b1;
      wake_event_q       <= 1'b0;
    end else begin
      state_q      <= state_d;
      // Rails follow the next state; S1 keeps power but stops the CPU [RQ4]
      main_power_q <= (state_d == `ST_S0) || (state_d == `ST_S1);
      cpu_run_q    <= (state_d == `ST_S0);
      wake_logic_power_q <= 1'b1; // [RQ4]
      wake_event_q <= wake_ok && (state_d == `ST_S0);
    end
  end
endmodule

`default_nettype wire

// [tb/pswake_assertions.sv]
// Port checker for the power-state sequencer, bound to every instance.
// Assumes one clock domain and state codes as the design documents them.
`timescale 1ns/10ps
`default_nettype none
module pswake_assertions (
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic       button_n,
  input wire logic [6:0] wake_in,
  input wire logic       wake_via_slot2,
  input wire logic       net_s5_enable,
  input wire logic [4:0] state_q,
  input wire logic       main_power_q,
  input wire logic       cpu_run_q,
  input wire logic       wake_logic_power_q,
  input wire logic       wake_event_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire s5  = state_q == 5'h08;
  wire slp = state_q == 5'h02 || state_q == 5'h04;
  logic [3:0] quiet_q = 4'h0;

  // Released long enough that no debounced press is still in flight
  always @(posedge clock) begin
    if (!button_n)
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hF)
      quiet_q <= quiet_q + 4'h1;
  end

  a_wake_logic_kept: assert property (wake_logic_power_q)
    else $error("wake logic unpowered");
  a_deep_sleep_off: assert property (state_q == 5'h04 || s5
    |-> !main_power_q && !cpu_run_q) else $error("power on in deep sleep");
  // A long press outranks a wake, so forced-off is also legal here
  a_sleep_wake_up: assert property (slp && |wake_in[5:0]
    |=> (state_q == 5'h01 && wake_event_q) || state_q == 5'h10)
    else $error("sleep wake missed");
  a_s5_local_refused: assert property (s5 && wake_in[2:0] == 3'h0
    && quiet_q >= 4'h8 |=> s5) else $error("S5 woke");
  a_s5_slot_only: assert property (s5 && !wake_via_slot2
    && quiet_q >= 4'h8 |=> s5) else $error("S5 slot woke");
  a_s5_net_gated: assert property (s5 && wake_in == 7'h02
    && !$past(net_s5_enable) && quiet_q >= 4'h8 |=> s5)
    else $error("net woke");
  a_riser_never: assert property (slp && wake_in == 7'h40
    && quiet_q >= 4'h8 |=> $stable(state_q)) else $error("riser ring woke");
  a_event_single: assert property (wake_event_q |=> !wake_event_q)
    else $error("wake event too long");
  a_forced_dark: assert property (state_q == 5'h10
    |-> !main_power_q && !cpu_run_q) else $error("forced off powered");
endmodule
bind power_state_wake_sequencer pswake_assertions i_pswake_assertions (
  .clock, .arst_n, .button_n, .wake_in, .wake_via_slot2, .net_s5_enable,
  .state_q, .main_power_q, .cpu_run_q, .wake_logic_power_q, .wake_event_q);
`default_nettype wire

// [tb/button_model.sv]
// Front-panel power button: held low for a commanded number of cycles.
// Assumes start is a one-cycle pulse on the bench clock.
`timescale 1ns/10ps
`default_nettype none
module button_model (
  input  wire logic       clock,
  input  wire logic [7:0] hold_len,
  input  wire logic       start,
  output wire logic       button_n
);
  logic [7:0] left_q = 8'h00;
  always @(posedge clock) begin
    if (start)
      left_q <= hold_len;
    else if (left_q != 8'h00)
      left_q <= left_q - 8'h01;
  end
  // Pull-up on the switch: released reads high
  assign button_n = left_q == 8'h00;
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the power-state sequencer, short counts.
// Assumes DEBOUNCE=2 and HOLD=20 stand for 10 ms and seven seconds.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int HOLD = 20;
  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  logic [1:0] os_req = 2'h0;
  logic       os_req_valid = 1'b0;
  logic [1:0] sleep_button_target = 2'h1;
  logic [6:0] wake_in = 7'h00;
  logic       wake_via_slot2 = 1'b0;
  logic       net_s5_enable = 1'b0;
  logic       pme_s5_enable = 1'b0;
  logic [7:0] hold_len = 8'h00;
  logic       start = 1'b0;
  wire        button_n;
  wire  [4:0] state_q;
  wire        main_power_q;
  wire        cpu_run_q;
  int         errors = 0;
  int         check_count = 0;
  always #25 clock = ~clock;
  button_model i_button_model (.clock, .hold_len, .start, .button_n);
  power_state_wake_sequencer #(.DEBOUNCE(2), .HOLD(HOLD))
    i_power_state_wake_sequencer (.clock, .arst_n, .button_n, .os_req,
    .os_req_valid, .sleep_button_target, .wake_in, .wake_via_slot2,
    .net_s5_enable, .pme_s5_enable, .state_q, .main_power_q,
    .cpu_run_q, .wake_logic_power_q(), .wake_event_q());
  task close_out;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task chk(input logic [4:0] exp);
    check_count++;
    if (state_q !== exp || main_power_q !== (exp < 5'h04)
        || cpu_run_q !== (exp == 5'h01)) begin
      errors++;
      $display("unexpected at %0t: state %h not %h", $time, state_q, exp);
    end
  endtask
  task press(input int n, input logic [4:0] exp);
    @(posedge clock);
    hold_len <= n[7:0];
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    cyc(n + 8);
    chk(exp);
  endtask
  task wake(input logic [6:0] w, input logic [4:0] exp);
    @(posedge clock);
    wake_in <= w;
    @(posedge clock);
    wake_in <= 7'h00;
    cyc(2);
    chk(exp);
  endtask
  task os(input logic [1:0] r, input logic [4:0] exp);
    @(posedge clock);
    os_req <= r;
    os_req_valid <= 1'b1;
    @(posedge clock);
    os_req_valid <= 1'b0;
    cyc(1);
    chk(exp);
  endtask
  task scen_button;
    press(4, 5'h01);
    press(4, 5'h02);
    press(HOLD, 5'h01);
    press(HOLD + 5, 5'h08);
  endtask
  task scen_sleep_wake;
    press(4, 5'h01);
    os(2'h2, 5'h04);
    wake(7'h40, 5'h04);
    wake(7'h10, 5'h01);
    os(2'h1, 5'h02);
    wake(7'h20, 5'h01);
    os(2'h3, 5'h08);
  endtask
  task scen_soft_off;
    wake(7'h38, 5'h08);
    wake(7'h01, 5'h08);
    @(posedge clock);
    wake_via_slot2 <= 1'b1;
    wake(7'h02, 5'h08);
    wake(7'h04, 5'h08);
    @(posedge clock);
    net_s5_enable <= 1'b1;
    pme_s5_enable <= 1'b1;
    wake(7'h02, 5'h01);
    os(2'h3, 5'h08);
    wake(7'h04, 5'h01);
    os(2'h3, 5'h08);
    wake(7'h01, 5'h01);
    @(posedge clock);
    sleep_button_target <= 2'h2;
    press(4, 5'h04);
    press(HOLD + 5, 5'h08);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    cyc(1);
    chk(5'h08);
    scen_button();
    scen_sleep_wake();
    scen_soft_off();
    close_out();
  end
endmodule
`default_nettype wire
